// File: core/rca_map.vh
// Constants for the receive comma aligner: register offsets, field
// positions, reset values and pipeline figures.
// Assumes inclusion by bare name from the aligner design files.
`ifndef RCA_MAP_VH
`define RCA_MAP_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define RCA_OFS_CFG          12'h000
`define RCA_OFS_MINUS_PAT    12'h004
`define RCA_OFS_PLUS_PAT     12'h008
`define RCA_OFS_MASK         12'h00C
`define RCA_OFS_STATUS       12'h010
`define RCA_OFS_COUNT        12'h014

// ----------------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------------
`define RCA_CFG_PLUS_ATTR    0
`define RCA_CFG_MINUS_ATTR   1
`define RCA_CFG_PLUS_RAISE   2
`define RCA_CFG_MINUS_RAISE  3
`define RCA_CFG_PAIRED       4
`define RCA_CFG_WIDTH        5
`define RCA_CFG_RESET        5'h0f

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define RCA_STAT_ALIGNED     8

// ----------------------------------------------------------------------
// Reset values of the comma patterns and match mask
// ----------------------------------------------------------------------
`define RCA_MINUS_PAT_RESET  10'h283
`define RCA_PLUS_PAT_RESET   10'h17c
`define RCA_MASK_RESET       10'h3ff

// ----------------------------------------------------------------------
// Datapath figures
// ----------------------------------------------------------------------
`define RCA_PATH_WIDTH       10
`define RCA_PIPE_DEPTH       3
`define RCA_SLIP_LOW_MIN     2

`endif

// File: core/rca_matcher.v
// Comma matcher: compares every candidate bit offset of the history
// window against the masked plus and minus patterns.
// Assumes the window holds three words, oldest bit at index 0.
`timescale 1ns/1ps
`default_nettype none

module rca_matcher #(
    parameter W = 10
) (
    input  wire [3*W-1:0] i_hist,
    input  wire [W-1:0]   i_plus_pat,
    input  wire [W-1:0]   i_minus_pat,
    input  wire [W-1:0]   i_mask,
    input  wire           i_paired,
    output wire [W-1:0]   o_plus_hit,
    output wire [W-1:0]   o_minus_hit
);

    // Mask bit at 0 makes that pattern bit a don't-care
    function mcmp;
        input [W-1:0] data;
        input [W-1:0] pat;
        input [W-1:0] mask;
        begin
            mcmp = (((data ^ pat) & mask) == {W{1'b0}});
        end
    endfunction

    genvar k;
    generate
        for (k = 0; k < W; k = k + 1) begin : g_ofs
            wire plus_here  = mcmp(i_hist[k +: W], i_plus_pat, i_mask);
            wire minus_here = mcmp(i_hist[k +: W], i_minus_pat, i_mask);
            wire minus_next = mcmp(i_hist[k+W +: W], i_minus_pat, i_mask);
            wire pair_here  = plus_here & minus_next;
            // Paired mode: plus then minus straight after, anchored on the plus
            assign o_plus_hit[k]  = i_paired ? pair_here : plus_here;
            assign o_minus_hit[k] = i_paired ? pair_here : minus_here;
        end
    endgenerate

endmodule // rca_matcher

`default_nettype wire

// File: core/rca_shifter.v
// Aligned-data pipeline: delays the raw window and extracts one word
// at the chosen bit offset into an output register.
// Assumes the offset is already below W.
`timescale 1ns/1ps
`default_nettype none

module rca_shifter #(
    parameter W   = 10,
    parameter OW  = 4,
    parameter DLY = 3
) (
    input  wire           i_clk,
    input  wire           i_arst_n,
    input  wire [2*W-1:0] i_win,
    input  wire [OW-1:0]  i_ofs,
    output reg  [W-1:0]   o_data
);

    reg [2*W-1:0] stage [0:DLY-1];
    integer i;

    // Delay gives the comma-seen flag a lead over the word itself
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (i = 0; i < DLY; i = i + 1) begin
                stage[i] <= {2*W{1'b0}};
            end
            o_data <= {W{1'b0}};
        end else begin
            stage[0] <= i_win;
            for (i = 1; i < DLY; i = i + 1) begin
                stage[i] <= stage[i-1];
            end
            o_data <= stage[DLY-1][i_ofs +: W];
        end
    end

endmodule // rca_shifter

`default_nettype wire

// File: core/rca_aligner.v
// Receive comma aligner: finds plus and minus commas in the incoming
// deserialised stream and moves the byte boundary onto them.
// Assumes one raw word per I_CLK, oldest bit in bit 0, inputs synchronous.
//
// Overview of operation
// - Byte-aligned flag is 1 when aligned to a comma boundary, else 0.
// - Aligned data appears several cycles after the byte-aligned flag rises.
// - With plus alignment attribute true, flag follows plus-comma alignment.
// - With minus alignment attribute true, flag follows minus-comma alignment.
// - Realign flag is 1 when comma detection moves the boundary, else 0.
// - Realignment may drop bits, so nearby data may hold errors.
// - Comma-seen is 1 when a comma is detected, 0 otherwise.
// - Comma-seen leads the comma on the output by several cycles.
// - Bypass adds one register of latency; the bypass path is shorter.
// - Minus align enable high lets minus commas realign; low ignores them.
// - Plus align enable high lets plus commas realign; low ignores them.
// - Slip request shifts the boundary by exactly one bit.
// - One slip per assertion that follows at least two low cycles, however long it is held.
// - While slip request is high, it overrides comma alignment.
// - Minus and plus patterns are 10-bit settings with fixed defaults.
// - A 10-bit mask picks pattern bits that must match.
// - Per-polarity settings decide comma-seen raising, not alignment.
// - Paired mode needs a plus comma immediately followed by minus.
`timescale 1ns/1ps
`default_nettype none
`include "rca_map.vh"

module rca_aligner #(
    parameter W   = `RCA_PATH_WIDTH,
    parameter DLY = `RCA_PIPE_DEPTH
) (
    input  wire          I_CLK,
    input  wire          I_ARST_N,
    // APB slave
    input  wire          PSEL,
    input  wire          PENABLE,
    input  wire          PWRITE,
    input  wire [11:0]   PADDR,
    input  wire [31:0]   PWDATA,
    output reg  [31:0]   PRDATA,
    output wire          PREADY,
    output wire          PSLVERR,
    // Fabric-side controls
    input  wire          I_ALIGN_BLOCK_USE,
    input  wire          I_MINUS_ALIGN_ENABLE,
    input  wire          I_PLUS_ALIGN_ENABLE,
    input  wire          I_SLIP_REQUEST,
    // Stream
    input  wire [W-1:0]  I_RX_DATA,
    output reg  [W-1:0]  O_RX_DATA,
    output reg           O_BYTE_ALIGNED_FLAG,
    output reg           O_REALIGN_FLAG,
    output reg           O_COMMA_SEEN
);

    localparam OW = (W > 1) ? $clog2(W) : 1;
    localparam [OW-1:0] OFS_LAST = W - 1;

    // ------------------------------------------------------------------
    // Configuration registers and event counters
    // ------------------------------------------------------------------
    reg [`RCA_CFG_WIDTH-1:0] cfg;
    reg [W-1:0]              minus_pattern;
    reg [W-1:0]              plus_pattern;
    reg [W-1:0]              comma_match_mask;
    reg [15:0]               comma_count;
    reg [15:0]               realign_count;

    wire plus_align_attr    = cfg[`RCA_CFG_PLUS_ATTR];
    wire minus_align_attr   = cfg[`RCA_CFG_MINUS_ATTR];
    wire plus_detect_raise  = cfg[`RCA_CFG_PLUS_RAISE];
    wire minus_detect_raise = cfg[`RCA_CFG_MINUS_RAISE];
    wire paired_mode        = cfg[`RCA_CFG_PAIRED];

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire access = PSEL & PENABLE;
    wire wr     = access & PWRITE;
    reg  mapped;

    always @* begin
        case (PADDR)
            `RCA_OFS_CFG, `RCA_OFS_MINUS_PAT, `RCA_OFS_PLUS_PAT,
            `RCA_OFS_MASK, `RCA_OFS_STATUS, `RCA_OFS_COUNT: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // Every access completes in its first access cycle
    assign PREADY  = 1'b1;
    assign PSLVERR = access & ~mapped;

    // ------------------------------------------------------------------
    // Raw history window: current word on top, two older words below
    // ------------------------------------------------------------------
    reg  [W-1:0]   word_prev;
    reg  [W-1:0]   word_old;
    wire [3*W-1:0] hist = {I_RX_DATA, word_prev, word_old};

    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            word_prev <= {W{1'b0}};
            word_old  <= {W{1'b0}};
        end else begin
            word_prev <= I_RX_DATA;
            word_old  <= word_prev;
        end
    end

    wire [W-1:0] plus_hit;
    wire [W-1:0] minus_hit;

    rca_matcher #(
        .W (W)
    ) u_matcher (
        .i_hist      (hist),
        .i_plus_pat  (plus_pattern),
        .i_minus_pat (minus_pattern),
        .i_mask      (comma_match_mask),
        .i_paired    (paired_mode),
        .o_plus_hit  (plus_hit),
        .o_minus_hit (minus_hit)
    );

    // ------------------------------------------------------------------
    // Candidate selection
    // ------------------------------------------------------------------
    // Only hits of an enabled polarity may move the boundary
    wire [W-1:0] align_cand = (plus_hit & {W{I_PLUS_ALIGN_ENABLE}})
                            | (minus_hit & {W{I_MINUS_ALIGN_ENABLE}});
    // Hits that also count toward the byte-aligned flag
    wire [W-1:0] flag_cand = (plus_hit & {W{I_PLUS_ALIGN_ENABLE & plus_align_attr}})
                           | (minus_hit & {W{I_MINUS_ALIGN_ENABLE & minus_align_attr}});

    reg [OW-1:0] pick;
    reg          pick_flag;
    integer      j;

    // Lowest offset wins, being the earliest comma in the stream
    always @* begin
        pick      = {OW{1'b0}};
        pick_flag = 1'b0;
        for (j = W - 1; j >= 0; j = j - 1) begin
            if (align_cand[j]) begin
                pick      = j[OW-1:0];
                pick_flag = flag_cand[j];
            end
        end
    end

    // ------------------------------------------------------------------
    // Slip request edge handling
    // ------------------------------------------------------------------
    reg       slip_prev;
    reg [1:0] slip_low_cnt;

    wire slip_rise = I_SLIP_REQUEST & ~slip_prev
                   & (slip_low_cnt >= `RCA_SLIP_LOW_MIN);

    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            slip_prev    <= 1'b0;
            slip_low_cnt <= 2'd`RCA_SLIP_LOW_MIN;
        end else begin
            slip_prev <= I_SLIP_REQUEST;
            if (I_SLIP_REQUEST) begin
                slip_low_cnt <= 2'd0;
            end else if (slip_low_cnt < `RCA_SLIP_LOW_MIN) begin
                slip_low_cnt <= slip_low_cnt + 2'd1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Boundary state and status flags
    // ------------------------------------------------------------------
    reg  [OW-1:0] ofs;
    reg  [OW-1:0] next_ofs;
    reg           next_aligned;
    reg           next_realign;
    wire          auto_ok   = I_ALIGN_BLOCK_USE & ~I_SLIP_REQUEST;
    wire          any_seen  = (|(plus_hit & {W{plus_detect_raise}}))
                            | (|(minus_hit & {W{minus_detect_raise}}));

    always @* begin
        next_ofs     = ofs;
        next_aligned = O_BYTE_ALIGNED_FLAG;
        next_realign = 1'b0;
        if (!I_ALIGN_BLOCK_USE) begin
            next_aligned = 1'b0;
        end else if (slip_rise) begin
            // Manual slip moves exactly one bit and loses comma lock
            next_ofs     = (ofs == OFS_LAST) ? {OW{1'b0}} : ofs + 1'b1;
            next_aligned = 1'b0;
        end else if (auto_ok && (|align_cand)) begin
            next_ofs = pick;
            // Dropped bits here can show as code or disparity errors downstream
            next_realign = (pick != ofs);
            if (pick_flag) begin
                next_aligned = 1'b1;
            end else if (pick != ofs) begin
                next_aligned = 1'b0;
            end
        end
    end

    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            ofs                 <= {OW{1'b0}};
            O_BYTE_ALIGNED_FLAG <= 1'b0;
            O_REALIGN_FLAG      <= 1'b0;
            O_COMMA_SEEN        <= 1'b0;
            comma_count         <= 16'h0000;
            realign_count       <= 16'h0000;
        end else begin
            ofs                 <= next_ofs;
            O_BYTE_ALIGNED_FLAG <= next_aligned;
            O_REALIGN_FLAG      <= next_realign;
            O_COMMA_SEEN        <= I_ALIGN_BLOCK_USE & any_seen;
            if (I_ALIGN_BLOCK_USE && any_seen) begin
                comma_count <= comma_count + 16'h0001;
            end
            if (next_realign) begin
                realign_count <= realign_count + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Data paths
    // ------------------------------------------------------------------
    wire [W-1:0] aligned_word;

    rca_shifter #(
        .W   (W),
        .OW  (OW),
        .DLY (DLY)
    ) u_shifter (
        .i_clk    (I_CLK),
        .i_arst_n (I_ARST_N),
        .i_win    (hist[2*W-1:0]),
        .i_ofs    (ofs),
        .o_data   (aligned_word)
    );

    // Bypass takes the raw word after one register, skipping the pipeline
    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_RX_DATA <= {W{1'b0}};
        end else if (I_ALIGN_BLOCK_USE) begin
            O_RX_DATA <= aligned_word;
        end else begin
            O_RX_DATA <= I_RX_DATA;
        end
    end

    // ------------------------------------------------------------------
    // Register writes and reads
    // ------------------------------------------------------------------
    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            cfg              <= `RCA_CFG_RESET;
            minus_pattern    <= `RCA_MINUS_PAT_RESET;
            plus_pattern     <= `RCA_PLUS_PAT_RESET;
            comma_match_mask <= `RCA_MASK_RESET;
        end else if (wr) begin
            case (PADDR)
                `RCA_OFS_CFG: begin
                    cfg <= PWDATA[`RCA_CFG_WIDTH-1:0];
                end
                `RCA_OFS_MINUS_PAT: begin
                    minus_pattern <= PWDATA[W-1:0];
                end
                `RCA_OFS_PLUS_PAT: begin
                    plus_pattern <= PWDATA[W-1:0];
                end
                `RCA_OFS_MASK: begin
                    comma_match_mask <= PWDATA[W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    always @* begin
        PRDATA = 32'h0000_0000;
        if (PSEL && !PWRITE) begin
            case (PADDR)
                `RCA_OFS_CFG: begin
                    PRDATA[`RCA_CFG_WIDTH-1:0] = cfg;
                end
                `RCA_OFS_MINUS_PAT: begin
                    PRDATA[W-1:0] = minus_pattern;
                end
                `RCA_OFS_PLUS_PAT: begin
                    PRDATA[W-1:0] = plus_pattern;
                end
                `RCA_OFS_MASK: begin
                    PRDATA[W-1:0] = comma_match_mask;
                end
                `RCA_OFS_STATUS: begin
                    PRDATA[OW-1:0]          = ofs;
                    PRDATA[`RCA_STAT_ALIGNED] = O_BYTE_ALIGNED_FLAG;
                end
                `RCA_OFS_COUNT: begin
                    PRDATA = {realign_count, comma_count};
                end
                default: begin
                    PRDATA = 32'h0000_0000;
                end
            endcase
        end
    end

endmodule // rca_aligner

`default_nettype wire

// File: verif/rca_aligner_asserts.sv
// Concurrent checks on the comma aligner top-level ports.
// Assumes a bind onto rca_aligner and a single I_CLK domain.
`timescale 1ns/1ps
`default_nettype none

module rca_aligner_asserts #(
    parameter W = 10
) (
    input wire logic         I_CLK,
    input wire logic         I_ARST_N,
    input wire logic         PSEL,
    input wire logic         PENABLE,
    input wire logic         PWRITE,
    input wire logic [11:0]  PADDR,
    input wire logic [31:0]  PWDATA,
    input wire logic [31:0]  PRDATA,
    input wire logic         PREADY,
    input wire logic         PSLVERR,
    input wire logic         I_ALIGN_BLOCK_USE,
    input wire logic         I_MINUS_ALIGN_ENABLE,
    input wire logic         I_PLUS_ALIGN_ENABLE,
    input wire logic         I_SLIP_REQUEST,
    input wire logic [W-1:0] I_RX_DATA,
    input wire logic [W-1:0] O_RX_DATA,
    input wire logic         O_BYTE_ALIGNED_FLAG,
    input wire logic         O_REALIGN_FLAG,
    input wire logic         O_COMMA_SEEN
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_ARST_N);

    a_bypass_flags: assert property ($past(!I_ALIGN_BLOCK_USE) |->
        !O_BYTE_ALIGNED_FLAG && !O_REALIGN_FLAG && !O_COMMA_SEEN)
        else $error("status flag high in bypass");
    a_bypass_latency: assert property ($past(!I_ALIGN_BLOCK_USE) |->
        O_RX_DATA == $past(I_RX_DATA))
        else $error("bypass path not one cycle");
    a_realign_pulse: assert property (O_REALIGN_FLAG |=> !O_REALIGN_FLAG)
        else $error("realign longer than one cycle");
    a_realign_cause: assert property (O_REALIGN_FLAG |-> $past(I_ALIGN_BLOCK_USE
        && !I_SLIP_REQUEST && (I_PLUS_ALIGN_ENABLE || I_MINUS_ALIGN_ENABLE)))
        else $error("realign without enabled alignment");
    a_comma_cause: assert property (O_COMMA_SEEN |-> $past(I_ALIGN_BLOCK_USE))
        else $error("comma seen while bypassed");
    a_slip_clears: assert property (I_SLIP_REQUEST && !$past(I_SLIP_REQUEST)
        && !$past(I_SLIP_REQUEST, 2) |=> !O_BYTE_ALIGNED_FLAG && !O_REALIGN_FLAG)
        else $error("accepted slip kept aligned flag");
    a_slip_holds: assert property (I_SLIP_REQUEST |=> !$rose(O_BYTE_ALIGNED_FLAG))
        else $error("alignment gained during slip");
    a_aligned_cause: assert property ($rose(O_BYTE_ALIGNED_FLAG) |->
        $past(I_ALIGN_BLOCK_USE && (I_PLUS_ALIGN_ENABLE || I_MINUS_ALIGN_ENABLE)))
        else $error("aligned flag rose without alignment");

    c_realign: cover property (O_REALIGN_FLAG);
    c_comma: cover property (O_COMMA_SEEN);
    c_slip: cover property ($rose(I_SLIP_REQUEST));
    c_bypass: cover property (!I_ALIGN_BLOCK_USE);
endmodule // rca_aligner_asserts

bind rca_aligner rca_aligner_asserts #(.W(W)) u_rca_aligner_asserts (
    .I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .I_ALIGN_BLOCK_USE(I_ALIGN_BLOCK_USE),
    .I_MINUS_ALIGN_ENABLE(I_MINUS_ALIGN_ENABLE), .I_PLUS_ALIGN_ENABLE(I_PLUS_ALIGN_ENABLE),
    .I_SLIP_REQUEST(I_SLIP_REQUEST), .I_RX_DATA(I_RX_DATA), .O_RX_DATA(O_RX_DATA),
    .O_BYTE_ALIGNED_FLAG(O_BYTE_ALIGNED_FLAG), .O_REALIGN_FLAG(O_REALIGN_FLAG),
    .O_COMMA_SEEN(O_COMMA_SEEN));

`default_nettype wire

// File: verif/rca_stream_src.sv
// Far-side stream model: serialises symbols and hands them on with a bit skew.
// Assumes one symbol per clock, skew below 10.
`timescale 1ns/1ps
`default_nettype none

module rca_stream_src (
    input  wire logic       i_clk,
    input  wire logic       i_arst_n,
    input  wire logic [9:0] i_sym,
    input  wire logic [3:0] i_skew,
    output logic      [9:0] o_word
);
    logic [9:0]  prev;
    logic [19:0] pair;

    // Older symbol in the low half, so bit 0 leaves first
    assign pair = {i_sym, prev} >> i_skew;

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            prev   <= 10'h000;
            o_word <= 10'h000;
        end else begin
            prev   <= i_sym;
            o_word <= pair[9:0];
        end
    end
endmodule // rca_stream_src

`default_nettype wire

// File: verif/rca_aligner_tb_top.sv
// Self-checking bench for the comma aligner: APB tasks plus stream scenarios.
// Assumes the design answers APB with PREADY and the stream model feeds I_RX_DATA.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin \
    n_checks++; \
    if ((g) !== (e)) begin \
        fail_count++; \
        $display("Error %s expected %0h seen %0h", nm, e, g); \
    end \
end

module rca_aligner_tb_top;
    localparam logic [9:0] PLUS  = 10'h17c;
    localparam logic [9:0] MINUS = 10'h283;
    localparam logic [9:0] FILL  = 10'h2aa;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        use_blk, men, pen, slip, aligned, realign, comma;
    logic [9:0]  sym, rx_in, rx_out, x;
    logic [3:0]  skew, o1;
    int          fail_count, n_checks, cyc, n_real, n_com, n_out, t_seen, t_out;
    int          r0, c0, q0;
    logic [31:0] rst_val [7] = '{32'h0000_000f, 32'h0000_0283, 32'h0000_017c,
                                 32'h0000_03ff, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

    rca_stream_src u_rca_stream_src (.i_clk(clk), .i_arst_n(rst_n), .i_sym(sym),
        .i_skew(skew), .o_word(rx_in));
    rca_aligner u_rca_aligner (.I_CLK(clk), .I_ARST_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .I_ALIGN_BLOCK_USE(use_blk),
        .I_MINUS_ALIGN_ENABLE(men), .I_PLUS_ALIGN_ENABLE(pen), .I_SLIP_REQUEST(slip),
        .I_RX_DATA(rx_in), .O_RX_DATA(rx_out), .O_BYTE_ALIGNED_FLAG(aligned),
        .O_REALIGN_FLAG(realign), .O_COMMA_SEEN(comma));

    always #4 clk = ~clk;

    // ----------------------------------------------------------------------
    // Event counters and hang guard
    // ----------------------------------------------------------------------
    always @(posedge clk) begin
        cyc <= cyc + 1;
        n_real <= n_real + realign;
        n_com <= n_com + comma;
        n_out <= n_out + (rx_out === PLUS);
        if (comma) t_seen <= cyc;
        if (rx_out === PLUS) t_out <= cyc;
        if (cyc == 5000) begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic mark();
        r0 = n_real;
        c0 = n_com;
        q0 = n_out;
    endtask

    // One symbol framed by filler, long enough for the pipeline to drain
    task automatic send(input logic [9:0] c);
        @(posedge clk);
        sym <= c;
        @(posedge clk);
        sym <= FILL;
        repeat (14) @(posedge clk);
    endtask

    task automatic slip_pulse(input int hi, input int lo);
        @(posedge clk);
        slip <= 1'b1;
        repeat (hi) @(posedge clk);
        slip <= 1'b0;
        repeat (lo) @(posedge clk);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        {clk, rst_n, psel, penable, pwrite, paddr, pwdata, slip, skew} = '0;
        {use_blk, men, pen} = 3'b111;
        {fail_count, n_checks, cyc, n_real, n_com, n_out, t_seen, t_out} = '0;
        sym = FILL;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        xfer(12'h010, 1'b1, 32'hffff_ffff);
        for (int i = 0; i < 7; i++) begin
            xfer(12'(4 * i), 1'b0, 32'h0000_0000);
            `CHK("reg", rst_val[i], rd)
            `CHK("slverr", (i == 6), err)
        end
        $display("test reset done");
        skew <= 4'h3;
        mark();
        send(PLUS);
        `CHK("aligned", 1'b1, aligned)
        `CHK("realign", 1, n_real - r0)
        `CHK("comma", 1, n_com - c0)
        `CHK("out", 1, n_out - q0)
        `CHK("lead", 1'b1, t_out > t_seen)
        xfer(12'h010, 1'b0, 32'h0000_0000);
        o1 = rd[3:0];
        mark();
        send(PLUS);
        `CHK("same", 0, n_real - r0)
        $display("test plus done");
        mark();
        slip_pulse(4, 3);
        xfer(12'h010, 1'b0, 32'h0000_0000);
        `CHK("slip ofs", 4'((o1 + 1) % 10), rd[3:0])
        `CHK("slip flag", 1'b0, aligned)
        slip_pulse(1, 1);
        slip_pulse(1, 3);
        @(posedge clk);
        slip <= 1'b1;
        send(PLUS);
        slip <= 1'b0;
        xfer(12'h010, 1'b0, 32'h0000_0000);
        `CHK("slip ofs", 4'((o1 + 4) % 10), rd[3:0])
        `CHK("slip wins", 0, n_real - r0)
        $display("test slip done");
        men <= 1'b0;
        skew <= 4'h6;
        mark();
        send(MINUS);
        `CHK("minus off", 0, n_real - r0)
        `CHK("minus seen", 1, n_com - c0)
        men <= 1'b1;
        mark();
        send(MINUS);
        `CHK("minus on", 1, n_real - r0)
        `CHK("aligned", 1'b1, aligned)
        pen <= 1'b0;
        skew <= 4'h2;
        mark();
        send(PLUS);
        `CHK("plus off", 0, n_real - r0)
        pen <= 1'b1;
        $display("test enables done");
        xfer(12'h000, 1'b1, 32'h0000_000b);
        mark();
        send(PLUS);
        `CHK("no raise", 0, n_com - c0)
        `CHK("still aligns", 1, n_real - r0)
        xfer(12'h000, 1'b1, 32'h0000_000f);
        xfer(12'h00c, 1'b1, 32'h0000_03fe);
        skew <= 4'h5;
        mark();
        send(PLUS ^ 10'h001);
        `CHK("masked", 1, n_real - r0)
        xfer(12'h000, 1'b1, 32'h0000_001f);
        skew <= 4'h1;
        mark();
        send(PLUS);
        `CHK("pair lone", 0, n_real - r0)
        @(posedge clk);
        sym <= PLUS;
        send(MINUS);
        `CHK("pair", 1, n_real - r0)
        `CHK("pair seen", 1, n_com - c0)
        xfer(12'h000, 1'b1, 32'h0000_000f);
        $display("test config done");
        use_blk <= 1'b0;
        skew <= 4'h0;
        repeat (3) @(posedge clk);
        // A lone marker word shows whether the bypass adds exactly one stage
        sym <= MINUS;
        @(posedge clk);
        sym <= FILL;
        repeat (2) @(posedge clk);
        x = rx_in;
        @(posedge clk);
        `CHK("bypass data", x, rx_out)
        `CHK("bypass flag", 1'b0, aligned)
        mark();
        send(PLUS);
        `CHK("bypass comma", 0, n_com - c0)
        use_blk <= 1'b1;
        $display("test bypass done");
        wrap_up();
    end
endmodule // rca_aligner_tb_top

`default_nettype wire
